// *** design/isc_pkg.sv ***
package isc_pkg;

    // ------------------------------------------------------------
    // sources and their slots in the request flag word
    // ------------------------------------------------------------
    localparam int ISC_NSRC = 7;
    localparam int ISC_SRC_KEY = 0;
    localparam int ISC_SRC_WDT_NMI = 1;
    localparam int ISC_SRC_WDT_INT = 2;
    localparam int ISC_SRC_TIMER_A = 3;
    localparam int ISC_SRC_TIMER_B = 4;
    localparam int ISC_SRC_LOW_VOLT = 5;
    localparam int ISC_SRC_NVM_DONE = 6;
    localparam int ISC_NKEY = 4;
    localparam int ISC_NLEVEL = 8;

    // ------------------------------------------------------------
    // vector table addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ISC_VEC_KEY = 16'h0002;
    localparam logic [15:0] ISC_VEC_WDT_NMI = 16'h0004;
    localparam logic [15:0] ISC_VEC_WDT_INT = 16'h0006;
    localparam logic [15:0] ISC_VEC_TIMER_A = 16'h0008;
    localparam logic [15:0] ISC_VEC_TIMER_B = 16'h000A;
    localparam logic [15:0] ISC_VEC_LOW_VOLT = 16'h000C;
    localparam logic [15:0] ISC_VEC_NVM_DONE = 16'h000E;

    // ------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ISC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ISC_MASK_OFS = 8'h04;
    localparam logic [7:0] ISC_FLAG_OFS = 8'h08;
    localparam logic [7:0] ISC_VEC_OFS = 8'h0C;
    localparam logic [4:0] ISC_CTRL_RST = 5'h00;
    localparam logic [6:0] ISC_MASK_RST = 7'h7C;
    localparam logic [6:0] ISC_MASKABLE = 7'h7C;
    localparam logic [6:0] ISC_NMI_BITS = 7'h03;
    localparam logic [6:0] ISC_FLAG_RST = 7'h00;
    localparam logic [15:0] ISC_VEC_RST = 16'h0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] lvLevel;
        logic wdtNmiMode;
        logic globalEnable;
    } isc_ctrl_t;

    typedef struct packed {
        logic intReq;
        logic nmi;
        logic [2:0] srcIdx;
        logic [15:0] vector;
    } isc_core_req_t;

    typedef struct packed {
        logic wdtOverflow;
        logic timerAMatch;
        logic timerBMatch;
        logic nvmWriteDone;
    } isc_evt_t;

endpackage : isc_pkg

// *** design/isc_edge_detect.sv ***
`timescale 1ns/1ns
module isc_edge_detect
    import isc_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] prev_reg;
    logic [W-1:0] prev_next;

    // ------------------------------------------------------------
    // last sampled level, one flop per line
    // ------------------------------------------------------------
    always_comb
    begin
        prev_next = level;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            prev_reg <= '0;
        else
            prev_reg <= prev_next;
    end

    // edges compare present level with the last one
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : gEdge
            assign rise[g] = level[g] & ~prev_reg[g];
            assign fall[g] = ~level[g] & prev_reg[g];
        end
    endgenerate

endmodule : isc_edge_detect

// *** design/isc_controller.sv ***
// Functional notes
// RL1: non-maskable requests ignore global enable flag
// RL2: non-maskable requests always beat maskable ones
// RL3: non-maskable request raises standby release
// RL4: maskable request raises standby release
// RL5: two non-maskable, five maskable internal sources
// RL6: key falling edge requests, vector 0002H
// RL7: watchdog mode overflow is non-maskable, 0004H
// RL8: interval mode overflow maskable, priority 0, 0006H
// RL9: timer A match, priority 1, 0008H
// RL10: timer B match, priority 2, 000AH
// RL11: low voltage request, priority 3, 000CH
// RL12: key edges count only in STOP mode
// RL13: any of four key inputs wakes STOP
// RL14: low voltage level software-chosen, off in STOP
// RL15: smallest priority number served first
// RL16: nonvolatile write done, lowest priority 4
// RL17: watchdog overflow goes one route only
// RL18: maskable needs mask clear and enable set; irqOut needs only mask clear
// RL19: flag held until acknowledged; events never lost
`timescale 1ns/1ns
module isc_controller
    import isc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ISC_NKEY-1:0] keyInputs,
    input wire logic stopMode,
    input wire logic [ISC_NLEVEL-1:0] supplyBelow,
    input wire isc_evt_t events,
    input wire logic intAck,
    output isc_core_req_t coreReq,
    output logic standbyRelease,
    output logic irqOut
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // index of the lowest set bit, the smallest priority number
    function automatic logic [2:0] firstSet(input logic [6:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = ISC_NSRC - 1; i >= 0; i--)
            if (v[i])
                idx = 3'(i);
        return idx;
    endfunction : firstSet

    function automatic logic [15:0] vecOf(input logic [2:0] idx);
        logic [15:0] v;
        unique case (idx)
            3'h0: v = ISC_VEC_KEY;
            3'h1: v = ISC_VEC_WDT_NMI;
            3'h2: v = ISC_VEC_WDT_INT;
            3'h3: v = ISC_VEC_TIMER_A;
            3'h4: v = ISC_VEC_TIMER_B;
            3'h5: v = ISC_VEC_LOW_VOLT;
            default: v = ISC_VEC_NVM_DONE;
        endcase
        return v;
    endfunction : vecOf

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic [4:0] edgeRise;
    logic [4:0] edgeFall;
    logic lvBelow;
    logic [6:0] setPulse;
    isc_ctrl_t ctrl_reg;
    isc_ctrl_t ctrl_next;
    isc_core_req_t coreReq_reg;
    isc_core_req_t coreReq_next;

    // detector follows the chosen level and sleeps in STOP
    assign lvBelow = supplyBelow[ctrl_reg.lvLevel] & ~stopMode; // [RL14]

    isc_edge_detect #(.W(5)) uEdge (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level({lvBelow, keyInputs}),
        .rise(edgeRise),
        .fall(edgeFall)
    );

    // one set pulse per source
    always_comb
    begin
        setPulse = '0;
        setPulse[ISC_SRC_KEY] = stopMode & (|edgeFall[3:0]); // [RL6] [RL12] [RL13]
        setPulse[ISC_SRC_WDT_NMI] = events.wdtOverflow & ctrl_reg.wdtNmiMode; // [RL7] [RL17]
        setPulse[ISC_SRC_WDT_INT] = events.wdtOverflow & ~ctrl_reg.wdtNmiMode; // [RL8] [RL17]
        setPulse[ISC_SRC_TIMER_A] = events.timerAMatch; // [RL9]
        setPulse[ISC_SRC_TIMER_B] = events.timerBMatch; // [RL10]
        setPulse[ISC_SRC_LOW_VOLT] = edgeRise[4]; // [RL11]
        setPulse[ISC_SRC_NVM_DONE] = events.nvmWriteDone; // [RL16] [RL5]
    end

    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    logic [6:0] mask_reg;
    logic [6:0] mask_next;
    logic [6:0] flag_reg;
    logic [6:0] flag_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic setup;
    logic wrAccess;
    logic mapped;
    logic [6:0] ackClear;
    logic [6:0] w1c;

    assign setup = psel & ~penable;
    assign wrAccess = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    assign mapped = (paddr == ISC_CTRL_OFS) || (paddr == ISC_MASK_OFS)
        || (paddr == ISC_FLAG_OFS) || (paddr == ISC_VEC_OFS);

    // acknowledge clears the flag that is presented now
    always_comb
    begin
        ackClear = '0;
        if (intAck && coreReq_reg.intReq)
            ackClear[coreReq_reg.srcIdx] = 1'b1; // [RL19]
        w1c = (wrAccess && paddr == ISC_FLAG_OFS) ? pwdata[6:0] : 7'h00;
    end

    // next register state; a new event wins over any clear
    always_comb
    begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if (wrAccess && paddr == ISC_CTRL_OFS)
            ctrl_next = isc_ctrl_t'(pwdata[4:0]);
        if (wrAccess && paddr == ISC_MASK_OFS)
            mask_next = pwdata[6:0] & ISC_MASKABLE;
        flag_next = (flag_reg & ~(ackClear | w1c)) | setPulse; // [RL19]
    end

    // read data and answer are prepared in the setup cycle
    always_comb
    begin
        prdata_next = 32'h0000_0000;
        pready_next = setup;
        pslverr_next = setup & ~mapped;
        if (setup && !pwrite)
        begin
            unique case (paddr)
                ISC_CTRL_OFS: prdata_next = {27'h0, ctrl_reg};
                ISC_MASK_OFS: prdata_next = {25'h0, mask_reg};
                ISC_FLAG_OFS: prdata_next = {25'h0, flag_reg};
                ISC_VEC_OFS: prdata_next = {11'h0, coreReq_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= isc_ctrl_t'(ISC_CTRL_RST);
            mask_reg <= ISC_MASK_RST;
            flag_reg <= ISC_FLAG_RST;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            flag_reg <= flag_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ------------------------------------------------------------
    // arbitration toward the core, on the next flag state
    // ------------------------------------------------------------
    logic standby_reg;
    logic standby_next;
    logic irq_reg;
    logic irq_next;
    logic [6:0] nmiPend;
    logic [6:0] maskPend;

    always_comb
    begin
        nmiPend = flag_next & ISC_NMI_BITS; // [RL1]
        maskPend = flag_next & ISC_MASKABLE & ~mask_next;
        coreReq_next = '0;
        if (|nmiPend)
        begin
            coreReq_next.intReq = 1'b1; // [RL2]
            coreReq_next.nmi = 1'b1;
            coreReq_next.srcIdx = firstSet(nmiPend);
        end
        else if ((|maskPend) && ctrl_next.globalEnable) // [RL18]
        begin
            coreReq_next.intReq = 1'b1;
            coreReq_next.srcIdx = firstSet(maskPend); // [RL15]
        end
        coreReq_next.vector = coreReq_next.intReq ? vecOf(coreReq_next.srcIdx) : ISC_VEC_RST;
        standby_next = (|nmiPend) | (|maskPend); // [RL3] [RL4]
        irq_next = (|nmiPend) | (|maskPend);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            coreReq_reg <= '0;
            standby_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            coreReq_reg <= coreReq_next;
            standby_reg <= standby_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign coreReq = coreReq_reg;
    assign standbyRelease = standby_reg;
    assign irqOut = irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence ackSeq;
        intAck && coreReq_reg.intReq && !setPulse[coreReq_reg.srcIdx];
    endsequence

    sequence flagGone(logic [2:0] idx);
        !flag_reg[idx];
    endsequence

    nmi_ignores_ie_a: assert property ( // [RL1]
        (|flag_reg[1:0]) |-> coreReq_reg.intReq && coreReq_reg.nmi)
        else $error("pending non-maskable request not presented");

    nmi_wins_a: assert property ( // [RL2]
        (|flag_reg[1:0]) && (|(flag_reg & ~mask_reg & ISC_MASKABLE))
        |-> coreReq_reg.nmi && coreReq_reg.srcIdx < 3'h2)
        else $error("maskable request won over non-maskable");

    standby_nmi_a: assert property ( // [RL3]
        (|flag_reg[1:0]) |-> standbyRelease)
        else $error("no standby release on non-maskable request");

    standby_mask_a: assert property ( // [RL4]
        (|(flag_reg & ~mask_reg & ISC_MASKABLE)) |-> standbyRelease)
        else $error("no standby release on maskable request");

    key_vector_a: assert property ( // [RL6]
        flag_reg[ISC_SRC_KEY] |-> coreReq_reg.vector == ISC_VEC_KEY)
        else $error("key request with wrong vector");

    key_stop_only_a: assert property ( // [RL12]
        $rose(flag_reg[ISC_SRC_KEY]) |-> $past(stopMode))
        else $error("key request outside STOP mode");

    wdt_route_a: assert property ( // [RL17]
        events.wdtOverflow |=> flag_reg[ISC_SRC_WDT_NMI] != flag_reg[ISC_SRC_WDT_INT]
        || $past(flag_reg[ISC_SRC_WDT_NMI] || flag_reg[ISC_SRC_WDT_INT]))
        else $error("watchdog overflow routed wrongly");

    lv_stop_a: assert property ( // [RL14]
        $rose(flag_reg[ISC_SRC_LOW_VOLT]) |-> !$past(stopMode))
        else $error("low voltage request raised in STOP mode");

    ie_gate_a: assert property ( // [RL18]
        !ctrl_reg.globalEnable && !(|flag_reg[1:0]) |-> !coreReq_reg.intReq)
        else $error("maskable request presented while disabled");

    prio_top_a: assert property ( // [RL15]
        coreReq_reg.intReq && !coreReq_reg.nmi && flag_reg[ISC_SRC_WDT_INT]
        && !mask_reg[ISC_SRC_WDT_INT] |-> coreReq_reg.vector == ISC_VEC_WDT_INT)
        else $error("priority 0 source not served first");

    ack_clear_a: assert property ( // [RL19]
        ackSeq |=> flagGone($past(coreReq_reg.srcIdx)))
        else $error("flag not cleared by acknowledge");

    event_kept_a: assert property ( // [RL19]
        events.timerAMatch |=> flag_reg[ISC_SRC_TIMER_A])
        else $error("timer A event lost");

endmodule : isc_controller

// *** verification/isc_core_model.sv ***
`timescale 1ns/1ns
module isc_core_model
    import isc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire isc_core_req_t coreReq,
    input wire logic ackOn,
    input wire logic [1:0] ackDelay,
    output logic intAck,
    output logic [15:0] lastVec,
    output logic [7:0] ackCount
);
    logic [1:0] waitCnt;

    // ----------------------------------------
    // core side: take the vector after ackDelay cycles
    // ----------------------------------------
    // one idle cycle after each ack lets the next request appear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            intAck <= 1'h0;
            waitCnt <= 2'h0;
            lastVec <= 16'h0;
            ackCount <= 8'h0;
        end
        else if (intAck)
        begin
            intAck <= 1'h0;
            waitCnt <= 2'h0;
        end
        else if (ackOn && (coreReq.intReq || coreReq.nmi))
        begin
            if (waitCnt == ackDelay)
            begin
                intAck <= 1'h1;
                lastVec <= coreReq.vector;
                ackCount <= ackCount + 8'h1;
            end
            else
                waitCnt <= waitCnt + 2'h1;
        end
    end
endmodule : isc_core_model

// *** verification/test_interrupt_source_controller.sv ***
`timescale 1ns/1ns
module test_interrupt_source_controller
    import isc_pkg::*;
;
    logic sys_clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] keyInputs;
    logic stopMode;
    logic [7:0] supplyBelow;
    isc_evt_t events;
    logic intAck;
    isc_core_req_t coreReq;
    logic standbyRelease;
    logic irqOut;
    logic ackOn;
    logic [1:0] ackDelay;
    logic [15:0] lastVec;
    logic [7:0] ackCount;
    logic [31:0] rd;
    logic err;
    int numErrors = 0;
    int samplesChecked = 0;
    int cycles = 0;
    logic [15:0] priVec [5] = '{16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E};

    isc_controller DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .keyInputs(keyInputs), .stopMode(stopMode),
        .supplyBelow(supplyBelow), .events(events), .intAck(intAck), .coreReq(coreReq),
        .standbyRelease(standbyRelease), .irqOut(irqOut));

    isc_core_model coreModel (.sys_clk(sys_clk), .rst_n(rst_n), .coreReq(coreReq),
        .ackOn(ackOn), .ackDelay(ackDelay), .intAck(intAck), .lastVec(lastVec),
        .ackCount(ackCount));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task stopTest;
    begin
        if (numErrors == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask : stopTest

    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        samplesChecked++;
        if (got !== exp)
        begin
            numErrors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask : chk

    // apb transfer; request held until pready is seen at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        @(posedge sys_clk);
        while (pready !== 1'h1)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    end
    endtask : apb

    task rdChk(input logic [7:0] a, input logic [31:0] exp);
    begin
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    end
    endtask : rdChk

    task settle;
    begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    end
    endtask : settle

    task pulse(input isc_evt_t e);
    begin
        @(posedge sys_clk);
        events <= e;
        @(posedge sys_clk);
        events <= 4'h0;
    end
    endtask : pulse

    task ack(input logic on);
    begin
        @(posedge sys_clk);
        ackOn <= on;
    end
    endtask : ack

    // wait for the core model to take a vector, then compare it
    task waitAck(input logic [15:0] exp);
        logic [7:0] c0;
    begin
        c0 = ackCount;
        while (ackCount === c0)
            @(negedge sys_clk);
        chk({16'h0, lastVec}, {16'h0, exp});
    end
    endtask : waitAck

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            numErrors++;
            stopTest();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        keyInputs = 4'hF;
        stopMode = 1'h0;
        supplyBelow = 8'h0;
        events = 4'h0;
        ackOn = 1'h0;
        ackDelay = 2'h0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'h1;
        // reset values and an unmapped place
        rdChk(8'h00, 32'h0);
        rdChk(8'h04, 32'h7C);
        rdChk(8'h08, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        // masked and disabled request, then unmask and enable
        pulse(4'h4);
        settle;
        chk({31'h0, irqOut}, 32'h0);
        rdChk(8'h08, 32'h8);
        apb(1'h1, 8'h04, 32'h0);
        settle;
        chk({31'h0, standbyRelease}, 32'h1);
        chk({31'h0, coreReq.intReq}, 32'h0);
        apb(1'h1, 8'h00, 32'h1);
        rdChk(8'h0C, 32'h130008);
        ack(1'h1);
        waitAck(16'h0008);
        settle;
        chk({31'h0, irqOut}, 32'h0);
        // all five maskable sources at once, slow core
        ack(1'h0);
        apb(1'h1, 8'h00, 32'h0D);
        @(posedge sys_clk);
        events <= 4'hF;
        supplyBelow <= 8'h08;
        @(posedge sys_clk);
        events <= 4'h0;
        settle;
        rdChk(8'h08, 32'h7C);
        rdChk(8'h0C, 32'h120006);
        ackDelay <= 2'h2;
        ack(1'h1);
        for (int i = 0; i < 5; i++)
            waitAck(priVec[i]);
        rdChk(8'h08, 32'h0);
        // watchdog routed non-maskable beats a pending timer
        ack(1'h0);
        supplyBelow <= 8'h0;
        ackDelay <= 2'h0;
        apb(1'h1, 8'h00, 32'h3);
        pulse(4'h2);
        pulse(4'h8);
        settle;
        rdChk(8'h08, 32'h12);
        rdChk(8'h0C, 32'h190004);
        ack(1'h1);
        waitAck(16'h0004);
        waitAck(16'h000A);
        // key wake in stop with global enable clear
        ack(1'h0);
        apb(1'h1, 8'h00, 32'h2);
        stopMode <= 1'h1;
        @(posedge sys_clk);
        events <= 4'h8;
        keyInputs <= 4'hB;
        @(posedge sys_clk);
        events <= 4'h0;
        keyInputs <= 4'hF;
        settle;
        chk({31'h0, standbyRelease}, 32'h1);
        rdChk(8'h08, 32'h3);
        ack(1'h1);
        waitAck(16'h0002);
        waitAck(16'h0004);
        // low voltage ignored in stop, keys ignored outside stop
        apb(1'h1, 8'h00, 32'h0D);
        supplyBelow <= 8'h08;
        settle;
        rdChk(8'h08, 32'h0);
        stopMode <= 1'h0;
        supplyBelow <= 8'h0;
        @(posedge sys_clk);
        keyInputs <= 4'h7;
        settle;
        rdChk(8'h08, 32'h0);
        stopTest();
    end
endmodule : test_interrupt_source_controller
